// ### odcrc_osc_model.sv
`timescale 1ns/1ps
module odcrc_osc_model
#(
   parameter int STARTUP = 4
)
(
   // Clock
   input wire logic aclk,
   // Source handshake
   input wire logic [3:0] src_run,
   output logic [3:0] src_ready
);
   int cnt [4];
   // Oscillator settles STARTUP cycles after start, drops one cycle after stop
   always @(posedge aclk)
   begin
      for (int s = 0; s < 4; s++)
      begin
         src_ready[s] <= src_run[s] && cnt[s] >= STARTUP - 1;
         cnt[s] <= src_run[s] ? ((cnt[s] < STARTUP) ? cnt[s] + 1 : cnt[s]) : 0;
      end
   end
endmodule

// ### odcrc_pkg.sv
package odcrc_pkg;

////////////////////////////////////////////////////////////////////////
// Sizes
localparam int NUM_PERIPH = 8;
localparam int NUM_GEN = 4;
localparam int NUM_SRC = 4;
localparam int NUM_GATE_BITS = 160;

////////////////////////////////////////////////////////////////////////
// Register indices, byte address is four times the index
localparam logic [5:0] IDX_CTRL = 6'h00;
localparam logic [5:0] IDX_IRQ_DIS = 6'h01;
localparam logic [5:0] IDX_IRQ_EN = 6'h02;
localparam logic [5:0] IDX_FLAGS = 6'h03;
localparam logic [5:0] IDX_CPU_CLOCK_DIVIDER = 6'h05;
localparam logic [5:0] IDX_AHB = 6'h10;
localparam logic [5:0] IDX_BRA = 6'h14;
localparam logic [5:0] IDX_BRB = 6'h18;
localparam logic [5:0] IDX_BRC = 6'h1c;
localparam logic [5:0] IDX_BRD = 6'h20;
localparam logic [5:0] IDX_CHAN_BASE = 6'h28;
localparam logic [5:0] IDX_GEN_BASE = 6'h30;
localparam logic [5:0] IDX_SRC_CTRL = 6'h34;
localparam logic [5:0] IDX_SRC_STAT = 6'h35;

////////////////////////////////////////////////////////////////////////
// Field positions
localparam int CFG_EN_BIT = 0;
localparam int CFG_SEL_LSB = 4;
localparam int FLAG_CLK_READY_BIT = 0;
localparam int FLAG_SRC_LSB = 1;

////////////////////////////////////////////////////////////////////////
// Reset values
localparam logic [7:0] CPU_CLOCK_DIVIDER_RST = 8'h01;
localparam logic [31:0] GATE_RST = 32'hffffffff;
localparam logic [3:0] GATED_RUN_RST = 4'hf;
localparam logic [7:0] FLAGS_RST = 8'h00;

////////////////////////////////////////////////////////////////////////
// Timing, one source and one divided period modelled as one aclk each
localparam int SRC_PERIOD_CYC = 1;
localparam int DIV_PERIOD_CYC = 1;
localparam logic [1:0] STOP_HOLD_CYC = 2'(SRC_PERIOD_CYC + DIV_PERIOD_CYC);
localparam logic [1:0] SYNC_CYC = 2'(SRC_PERIOD_CYC + DIV_PERIOD_CYC);

////////////////////////////////////////////////////////////////////////
// Bus answers
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_DECERR = 2'h3;

////////////////////////////////////////////////////////////////////////
// Carriers
typedef struct packed {
   logic en;
   logic [1:0] sel;
} odcrc_cfg_t;

typedef struct packed {
   logic [31:0] data;
   logic [3:0] strb;
   logic [5:0] idx;
} odcrc_wr_t;

endpackage

// ### odcrc_properties.sv
`timescale 1ns/1ps
module odcrc_properties
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // Clock path
   input wire logic [odcrc_pkg::NUM_PERIPH-1:0] periph_clk_ok,
   input wire logic [odcrc_pkg::NUM_SRC-1:0] src_ready,
   input wire logic [odcrc_pkg::NUM_SRC-1:0] src_run,
   // Peripheral gate
   input wire logic [odcrc_pkg::NUM_GATE_BITS-1:0] bus_clk_gate,
   input wire logic [7:0] pif_idx,
   input wire logic [31:0] pif_rdata_in,
   input wire logic pif_wr_in,
   input wire logic [31:0] pif_rdata,
   input wire logic pif_wr
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_pif_masked;
      !bus_clk_gate[pif_idx] |=> pif_rdata == 32'h0 && !pif_wr;
   endproperty
   a_pif_masked: assert property (p_pif_masked) else $error("masked access leaked");
   property p_pif_pass;
      bus_clk_gate[pif_idx] |=> pif_rdata == $past(pif_rdata_in) && pif_wr == $past(pif_wr_in);
   endproperty
   a_pif_pass: assert property (p_pif_pass) else $error("open access not passed");
   property p_b_answer;
      awvalid && awready && wvalid && wready |-> ##2 bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer late");
   property p_r_answer;
      arvalid && arready |=> rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_b_release;
      bvalid && bready |=> !bvalid;
   endproperty
   a_b_release: assert property (p_b_release) else $error("write answer stuck");
   property p_r_release;
      rvalid && rready |=> !rvalid;
   endproperty
   a_r_release: assert property (p_r_release) else $error("read answer stuck");
   property p_aw_block;
      bvalid |-> !awready && !wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
   property p_ar_block;
      rvalid |-> !arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_clk_ok_src;
      $rose(|periph_clk_ok) |-> $past(|(src_run & src_ready), 2);
   endproperty
   a_clk_ok_src: assert property (p_clk_ok_src) else $error("clock usable too early");
endmodule

bind odcrc_top odcrc_properties u_odcrc_properties (.aclk, .aresetn, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .periph_clk_ok,
   .src_ready, .src_run, .bus_clk_gate, .pif_idx, .pif_rdata_in, .pif_wr_in, .pif_rdata,
   .pif_wr);

// ### odcrc_tb.sv
`timescale 1ns/1ps
module odcrc_tb;
   localparam int STARTUP = 4;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [7:0] awaddr = 8'h0;
   logic [7:0] araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [7:0] periph_req = 8'h0;
   logic [7:0] periph_enabled = 8'hff;
   logic [7:0] sleep_keep_running = 8'h0;
   logic standby = 1'b0;
   logic write_protect_on = 1'b0;
   logic [7:0] pif_idx = 8'h0;
   logic [31:0] pif_rdata_in = 32'h0;
   logic pif_wr_in = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pif_wr, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, pif_rdata;
   logic [7:0] periph_clk_ok, cpu_divider_value;
   logic [3:0] src_ready, src_run;
   logic [159:0] bus_clk_gate;
   logic [31:0] m [64];
   logic [5:0] rl [12] = '{6'h0, 6'h1, 6'h2, 6'h3, 6'h4, 6'h5, 6'h10, 6'h14, 6'h18, 6'h1c,
      6'h20, 6'h34};
   logic [31:0] seed = 32'h78dd8d73;
   int errors = 0;
   int cmp_count = 0;

   odcrc_top u_odcrc_top (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .periph_req, .periph_enabled,
      .sleep_keep_running, .standby, .write_protect_on, .periph_clk_ok, .src_ready, .src_run,
      .bus_clk_gate, .cpu_divider_value, .pif_idx, .pif_rdata_in, .pif_wr_in, .pif_rdata,
      .pif_wr, .irq);
   odcrc_osc_model #(.STARTUP(STARTUP)) u_odcrc_osc_model (.aclk, .src_run, .src_ready);

   always #2.5 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [1:0] er(input logic [5:0] i);
      return (i inside {[6'h0:6'h3], 6'h5, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h20, [6'h28:6'h35]})
         ? odcrc_pkg::RESP_OKAY : odcrc_pkg::RESP_DECERR;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int n, input int lo, input int hi);
      cmp_count++;
      if (n < lo || n > hi)
      begin
         errors++;
         $display("unexpected at %0t: latency %0d not in %0d..%0d", $time, n, lo, hi);
      end
   endtask

   task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s);
      awvalid <= 1'b1;
      awaddr <= {i, 2'h0};
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er(i)));
      @(posedge aclk);
   endtask

   task automatic rd(input logic [5:0] i, input logic [31:0] e);
      arvalid <= 1'b1;
      araddr <= {i, 2'h0};
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, e);
      chk(32'(rresp), 32'(er(i)));
      @(posedge aclk);
   endtask

   // Channel p to generator g, generator g to source s
   task automatic cfg(input int p, input int g, input int s, input bit ce, input bit ge);
      wr(6'(odcrc_pkg::IDX_CHAN_BASE + p), {26'h0, 2'(g), 3'h0, ce}, 4'h1);
      wr(6'(odcrc_pkg::IDX_GEN_BASE + g), {26'h0, 2'(s), 3'h0, ge}, 4'h1);
   endtask

   // k: 0 run, 1 ready, 2 clock usable, 3 interrupt
   task automatic wt(input int k, input int i, input logic v, output int n);
      logic [7:0] b;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         b = (k == 0) ? 8'(src_run) : (k == 1) ? 8'(src_ready) : (k == 2) ? periph_clk_ok : 8'(irq);
      end while (b[i] !== v && n < 60);
   endtask

   task automatic path(input int p, input int g, input int s);
      int n;
      cfg(p, g, s, 1'b1, 1'b1);
      periph_req[p] <= 1'b1;
      wt(0, s, 1'b1, n);
      chk_rng(n - 1, 1, 2);
      chk(32'(src_run), 32'(1 << s));
      wt(1, s, 1'b1, n);
      wt(2, p, 1'b1, n);
      chk_rng(n, 2, 4);
      periph_req[p] <= 1'b0;
      wt(0, s, 1'b0, n);
      chk_rng(n - 1, 2, 4);
   endtask

   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int k, n;
      logic [31:0] d;
      logic [5:0] ga;
      logic [3:0] st;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      m = '{default: 32'h0};
      for (int j = 0; j < 5; j++)
         m[16 + 4 * j] = odcrc_pkg::GATE_RST;
      m[5] = 32'(odcrc_pkg::CPU_CLOCK_DIVIDER_RST);
      m[6'h34] = 32'(odcrc_pkg::GATED_RUN_RST);
      foreach (rl[j])
         rd(rl[j], m[rl[j]]);
      rd(6'h3c, 32'h0);
      wr(6'h3c, rnd(), 4'hf);
      for (int s = 0; s < 4; s++)
         path(2 * s + 1, 3 - s, s);
      // Two requests share source 0
      cfg(4, 3, 0, 1'b1, 1'b1);
      periph_req <= 8'h12;
      repeat (12) @(posedge aclk);
      periph_req <= 8'h10;
      repeat (8) @(posedge aclk);
      chk(32'(src_run), 32'h1);
      periph_req <= 8'h0;
      wt(0, 0, 1'b0, n);
      chk_rng(n - 1, 2, 4);
      for (int j = 0; j < 4; j++)
      begin
         periph_enabled[1] <= (j != 0);
         standby <= (j == 3);
         cfg(1, 3, 0, j != 1, j != 2);
         periph_req[1] <= 1'b1;
         repeat (8) @(posedge aclk);
         chk(32'(src_run), 32'h0);
         periph_req[1] <= 1'b0;
      end
      sleep_keep_running[1] <= 1'b1;
      path(1, 3, 0);
      standby <= 1'b0;
      // Free-running source and its ready interrupt
      wr(odcrc_pkg::IDX_FLAGS, 32'hff, 4'h1);
      wr(odcrc_pkg::IDX_IRQ_EN, 32'h8, 4'h1);
      wr(odcrc_pkg::IDX_SRC_CTRL, 32'hb, 4'h1);
      wt(0, 2, 1'b1, n);
      chk_rng(n, 1, 3);
      wt(3, 0, 1'b1, n);
      chk_rng(n, 1, 20);
      wr(odcrc_pkg::IDX_IRQ_DIS, 32'h8, 4'h1);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
      rd(odcrc_pkg::IDX_FLAGS, 32'h8);
      chk(32'(src_run), 32'h4);
      rd(odcrc_pkg::IDX_SRC_STAT, 32'h44);
      wr(odcrc_pkg::IDX_IRQ_EN, 32'h8, 4'h1);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h1);
      wr(odcrc_pkg::IDX_FLAGS, 32'h8, 4'h1);
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0);
      d = rnd();
      wr(odcrc_pkg::IDX_CPU_CLOCK_DIVIDER, d, 4'h1);
      rd(odcrc_pkg::IDX_FLAGS, 32'h1);
      chk(32'(cpu_divider_value), 32'(d[7:0]));
      wr(odcrc_pkg::IDX_SRC_CTRL, 32'hf, 4'h1);
      wt(0, 2, 1'b0, n);
      chk(32'(src_run), 32'h0);
      // Gate registers, lane strobes, then protected writes
      for (int j = 0; j < 10; j++)
      begin
         ga = 6'(16 + 4 * (j % 5));
         d = rnd();
         st = d[3:0] ^ d[31:28];
         write_protect_on <= (j >= 5);
         wr(ga, d, st);
         for (int b = 0; b < 4; b++)
            if (j < 5 && st[b])
               m[ga][8 * b +: 8] = d[8 * b +: 8];
         rd(ga, m[ga]);
         chk(bus_clk_gate[32 * (j % 5) +: 32], m[ga]);
      end
      write_protect_on <= 1'b0;
      for (int j = 0; j < 40; j++)
      begin
         k = int'(rnd() % 160);
         d = rnd();
         pif_idx <= 8'(k);
         pif_rdata_in <= d;
         pif_wr_in <= d[0];
         @(posedge aclk);
         @(posedge aclk);
         chk(pif_rdata, m[16 + 4 * (k / 32)][k % 32] ? d : 32'h0);
         chk(32'(pif_wr), 32'(m[16 + 4 * (k / 32)][k % 32] & d[0]));
      end
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      stop_test();
   end
endmodule

// ### odcrc_top.sv
`timescale 1ns/1ps
// What this block does
// R1: An on-demand source stays stopped with no request and runs while any request is active.
// R2: A peripheral request travels through its channel and generator to that generator's source.
// R3: A request counts only while peripheral, channel and generator are all enabled.
// R4: A usable clock follows a request within startup plus two source and two divided periods.
// R5: A usable clock follows a request no sooner than startup plus one source and one divided period.
// R6: A source stops between one and two source-plus-divided periods after its last request.
// R7: Clearing a source's on-demand bit keeps that source running regardless of requests.
// R8: In standby only requests from modules with their keep-running bit set are honoured.
// R9: A peripheral whose interface is masked reads zero and has its writes discarded.
// R10: Software sets up a running source, an enabled generator, channel and unmasked interface.
// R11: Registers take 8, 16 and 32-bit accesses, each byte lane on its own.
// R12: Protectable registers ignore writes while write protection is on.
// R13: A source's request is the OR of all qualified requests whose path selects it.
// R14: Each bus clock mask bit gates one peripheral, a cleared bit masks its interface.
module odcrc_top
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Peripheral requests
   input wire logic [odcrc_pkg::NUM_PERIPH-1:0] periph_req,
   input wire logic [odcrc_pkg::NUM_PERIPH-1:0] periph_enabled,
   input wire logic [odcrc_pkg::NUM_PERIPH-1:0] sleep_keep_running,
   input wire logic standby,
   input wire logic write_protect_on,
   output logic [odcrc_pkg::NUM_PERIPH-1:0] periph_clk_ok,
   // Clock sources
   input wire logic [odcrc_pkg::NUM_SRC-1:0] src_ready,
   output logic [odcrc_pkg::NUM_SRC-1:0] src_run,
   // Bus clock gates
   output logic [odcrc_pkg::NUM_GATE_BITS-1:0] bus_clk_gate,
   output logic [7:0] cpu_divider_value,
   // Peripheral interface gate
   input wire logic [7:0] pif_idx,
   input wire logic [31:0] pif_rdata_in,
   input wire logic pif_wr_in,
   output logic [31:0] pif_rdata,
   output logic pif_wr,
   // Interrupt
   output logic irq
);

////////////////////////////////////////////////////////////////////////
// Register state
odcrc_pkg::odcrc_cfg_t chan_q [odcrc_pkg::NUM_PERIPH];
odcrc_pkg::odcrc_cfg_t chan_d [odcrc_pkg::NUM_PERIPH];
odcrc_pkg::odcrc_cfg_t gen_q [odcrc_pkg::NUM_GEN];
odcrc_pkg::odcrc_cfg_t gen_d [odcrc_pkg::NUM_GEN];
logic [31:0] gate_q [5];
logic [31:0] gate_d [5];
logic [3:0] gated_run_q, gated_run_d;
logic [7:0] cpu_clock_divider_q, cpu_clock_divider_d;
logic [7:0] mask_q, mask_d;
logic [7:0] flags_q, flags_d;
logic div_upd_q, div_upd_d;
logic irq_q, irq_d;

////////////////////////////////////////////////////////////////////////
// Bus state
odcrc_pkg::odcrc_wr_t wr_q, wr_d;
logic aw_v_q, aw_v_d, w_v_q, w_v_d;
logic awready_q, awready_d, wready_q, wready_d;
logic b_v_q, b_v_d;
logic [1:0] b_r_q, b_r_d;
logic arready_q, arready_d, r_v_q, r_v_d;
logic [31:0] r_d_q, r_d_d;
logic [1:0] r_r_q, r_r_d;
logic [31:0] pif_rdata_q, pif_rdata_d;
logic pif_wr_q, pif_wr_d;

////////////////////////////////////////////////////////////////////////
// Source and path signals
logic qual [odcrc_pkg::NUM_PERIPH];
logic [1:0] path_src [odcrc_pkg::NUM_PERIPH];
logic ok_q [odcrc_pkg::NUM_SRC];
logic ok_evt [odcrc_pkg::NUM_SRC];
logic run_q [odcrc_pkg::NUM_SRC];
logic clk_ok_q [odcrc_pkg::NUM_PERIPH];
logic [31:0] rd_val;
logic rd_hit;
logic do_wr, wr_hit;
logic [31:0] bmask;
logic [odcrc_pkg::NUM_GATE_BITS-1:0] gates_all;

assign gates_all = {gate_q[4], gate_q[3], gate_q[2], gate_q[1], gate_q[0]};
assign bus_clk_gate = gates_all;
assign cpu_divider_value = cpu_clock_divider_q;
assign irq = irq_q;
assign awready = awready_q;
assign wready = wready_q;
assign bvalid = b_v_q;
assign bresp = b_r_q;
assign arready = arready_q;
assign rvalid = r_v_q;
assign rdata = r_d_q;
assign rresp = r_r_q;
assign pif_rdata = pif_rdata_q;
assign pif_wr = pif_wr_q;

////////////////////////////////////////////////////////////////////////
// Peripheral path qualification
for (genvar p = 0; p < odcrc_pkg::NUM_PERIPH; p++)
begin : g_periph
   logic clk_ok_d;
   always_comb
   begin
      path_src[p] = gen_q[chan_q[p].sel].sel; // R2
      qual[p] = periph_req[p] && periph_enabled[p] && chan_q[p].en
         && gen_q[chan_q[p].sel].en // R3
         && (!standby || sleep_keep_running[p]); // R8
      clk_ok_d = periph_enabled[p] && chan_q[p].en && gen_q[chan_q[p].sel].en
         && ok_q[path_src[p]]; // R4
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_ok_q[p] <= 1'b0;
      else
         clk_ok_q[p] <= clk_ok_d;
   end
   assign periph_clk_ok[p] = clk_ok_q[p];
end

////////////////////////////////////////////////////////////////////////
// Per source start, stop and ready tracking
for (genvar s = 0; s < odcrc_pkg::NUM_SRC; s++)
begin : g_src
   logic req_any;
   logic [1:0] hold_q, hold_d;
   logic [1:0] sync_q, sync_d;
   logic run_d, ok_d;
   always_comb
   begin
      req_any = 1'b0;
      for (int p = 0; p < odcrc_pkg::NUM_PERIPH; p++)
      begin
         if (qual[p] && path_src[p] == 2'(s))
            req_any = 1'b1; // R13
      end
      if (req_any)
         hold_d = odcrc_pkg::STOP_HOLD_CYC;
      else if (hold_q != 2'h0)
         hold_d = hold_q - 2'h1; // R6
      else
         hold_d = 2'h0;
      run_d = !gated_run_q[s] || req_any || hold_q != 2'h0; // R1 R7
      if (run_q[s] && src_ready[s])
         sync_d = (sync_q == odcrc_pkg::SYNC_CYC) ? sync_q : sync_q + 2'h1; // R5
      else
         sync_d = 2'h0;
      ok_d = sync_d == odcrc_pkg::SYNC_CYC;
      ok_evt[s] = ok_d && !ok_q[s];
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hold_q <= 2'h0;
         sync_q <= 2'h0;
         run_q[s] <= 1'b0;
         ok_q[s] <= 1'b0;
      end
      else
      begin
         hold_q <= hold_d;
         sync_q <= sync_d;
         run_q[s] <= run_d;
         ok_q[s] <= ok_d;
      end
   end
   assign src_run[s] = run_q[s];
end

////////////////////////////////////////////////////////////////////////
// Read decode
always_comb
begin
   rd_val = 32'h00000000;
   rd_hit = 1'b1;
   unique case (araddr[7:2])
      odcrc_pkg::IDX_CTRL: rd_val = 32'h00000000;
      odcrc_pkg::IDX_IRQ_DIS, odcrc_pkg::IDX_IRQ_EN: rd_val = {24'h000000, mask_q};
      odcrc_pkg::IDX_FLAGS: rd_val = {24'h000000, flags_q};
      odcrc_pkg::IDX_CPU_CLOCK_DIVIDER: rd_val = {24'h000000, cpu_clock_divider_q};
      odcrc_pkg::IDX_AHB: rd_val = gate_q[0];
      odcrc_pkg::IDX_BRA: rd_val = gate_q[1];
      odcrc_pkg::IDX_BRB: rd_val = gate_q[2];
      odcrc_pkg::IDX_BRC: rd_val = gate_q[3];
      odcrc_pkg::IDX_BRD: rd_val = gate_q[4];
      odcrc_pkg::IDX_SRC_CTRL: rd_val = {28'h0000000, gated_run_q};
      odcrc_pkg::IDX_SRC_STAT:
         rd_val = {24'h000000, ok_q[3], ok_q[2], ok_q[1], ok_q[0],
            run_q[3], run_q[2], run_q[1], run_q[0]};
      default:
      begin
         if (araddr[7:5] == 3'h5)
            rd_val = {26'h0000000, chan_q[araddr[4:2]].sel, 3'h0,
               chan_q[araddr[4:2]].en};
         else if (araddr[7:4] == 4'hc)
            rd_val = {26'h0000000, gen_q[araddr[3:2]].sel, 3'h0,
               gen_q[araddr[3:2]].en};
         else
            rd_hit = 1'b0;
      end
   endcase
end

////////////////////////////////////////////////////////////////////////
// Bus handshakes
always_comb
begin
   wr_d = wr_q;
   aw_v_d = aw_v_q;
   w_v_d = w_v_q;
   b_v_d = b_v_q;
   b_r_d = b_r_q;
   r_v_d = r_v_q;
   r_d_d = r_d_q;
   r_r_d = r_r_q;
   do_wr = aw_v_q && w_v_q && !b_v_q;
   wr_hit = wr_q.idx <= odcrc_pkg::IDX_SRC_STAT
      && (wr_q.idx <= odcrc_pkg::IDX_CPU_CLOCK_DIVIDER || wr_q.idx >= odcrc_pkg::IDX_CHAN_BASE
      || (wr_q.idx[1:0] == 2'h0 && wr_q.idx >= odcrc_pkg::IDX_AHB))
      && wr_q.idx != 6'h04
      && (wr_q.idx <= odcrc_pkg::IDX_BRD || wr_q.idx >= odcrc_pkg::IDX_CHAN_BASE);
   if (b_v_q && bready)
      b_v_d = 1'b0;
   if (awvalid && awready_q)
   begin
      aw_v_d = 1'b1;
      wr_d.idx = awaddr[7:2];
   end
   if (wvalid && wready_q)
   begin
      w_v_d = 1'b1;
      wr_d.data = wdata;
      wr_d.strb = wstrb; // R11
   end
   if (do_wr)
   begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      b_v_d = 1'b1;
      b_r_d = wr_hit ? odcrc_pkg::RESP_OKAY : odcrc_pkg::RESP_DECERR;
   end
   awready_d = !aw_v_d && !b_v_d;
   wready_d = !w_v_d && !b_v_d;
   if (r_v_q && rready)
      r_v_d = 1'b0;
   if (arvalid && arready_q)
   begin
      r_v_d = 1'b1;
      r_d_d = rd_val;
      r_r_d = rd_hit ? odcrc_pkg::RESP_OKAY : odcrc_pkg::RESP_DECERR;
   end
   arready_d = !r_v_d;
end

////////////////////////////////////////////////////////////////////////
// Register writes and interrupt
always_comb
begin
   logic wr_ok;
   logic [7:0] flag_set;
   wr_ok = do_wr && !write_protect_on; // R12
   flag_set = 8'h00;
   chan_d = chan_q;
   gen_d = gen_q;
   gate_d = gate_q;
   gated_run_d = gated_run_q;
   cpu_clock_divider_d = cpu_clock_divider_q;
   mask_d = mask_q;
   div_upd_d = 1'b0;
   for (int i = 0; i < 4; i++)
      bmask[8*i +: 8] = {8{wr_q.strb[i]}}; // R11
   flag_set[odcrc_pkg::FLAG_CLK_READY_BIT] = div_upd_q;
   for (int s = 0; s < odcrc_pkg::NUM_SRC; s++)
      flag_set[odcrc_pkg::FLAG_SRC_LSB + s] = ok_evt[s];
   flags_d = flags_q | flag_set;
   if (do_wr && wr_q.idx == odcrc_pkg::IDX_FLAGS && wr_q.strb[0])
      flags_d = (flags_q & ~wr_q.data[7:0]) | flag_set;
   if (wr_ok && wr_q.strb[0])
   begin
      if (wr_q.idx == odcrc_pkg::IDX_IRQ_DIS)
         mask_d = mask_q & ~wr_q.data[7:0];
      if (wr_q.idx == odcrc_pkg::IDX_IRQ_EN)
         mask_d = mask_q | wr_q.data[7:0];
      if (wr_q.idx == odcrc_pkg::IDX_CPU_CLOCK_DIVIDER)
      begin
         cpu_clock_divider_d = wr_q.data[7:0];
         div_upd_d = 1'b1;
      end
      if (wr_q.idx == odcrc_pkg::IDX_SRC_CTRL)
         gated_run_d = wr_q.data[3:0]; // R7
      if (wr_q.idx[5:3] == 3'h5)
      begin
         chan_d[wr_q.idx[2:0]].en = wr_q.data[odcrc_pkg::CFG_EN_BIT];
         chan_d[wr_q.idx[2:0]].sel = wr_q.data[odcrc_pkg::CFG_SEL_LSB +: 2];
      end
      if (wr_q.idx[5:2] == 4'hc)
      begin
         gen_d[wr_q.idx[1:0]].en = wr_q.data[odcrc_pkg::CFG_EN_BIT];
         gen_d[wr_q.idx[1:0]].sel = wr_q.data[odcrc_pkg::CFG_SEL_LSB +: 2];
      end
   end
   if (wr_ok && wr_q.idx >= odcrc_pkg::IDX_AHB && wr_q.idx <= odcrc_pkg::IDX_BRD
      && wr_q.idx[1:0] == 2'h0)
      gate_d[3'(wr_q.idx[4:2] - 3'h4)] = (gate_q[3'(wr_q.idx[4:2] - 3'h4)] & ~bmask)
         | (wr_q.data & bmask); // R14
   irq_d = |(flags_d & mask_d);
end

////////////////////////////////////////////////////////////////////////
// Peripheral interface gate
always_comb
begin
   logic open;
   open = (pif_idx < 8'(odcrc_pkg::NUM_GATE_BITS)) && gates_all[pif_idx]; // R14
   pif_rdata_d = open ? pif_rdata_in : 32'h00000000; // R9
   pif_wr_d = open && pif_wr_in; // R9
end

////////////////////////////////////////////////////////////////////////
// Registers
always_ff @(posedge aclk)
begin
   if (!aresetn)
   begin
      for (int p = 0; p < odcrc_pkg::NUM_PERIPH; p++)
         chan_q[p] <= '0;
      for (int g = 0; g < odcrc_pkg::NUM_GEN; g++)
         gen_q[g] <= '0;
      for (int i = 0; i < 5; i++)
         gate_q[i] <= odcrc_pkg::GATE_RST;
      gated_run_q <= odcrc_pkg::GATED_RUN_RST;
      cpu_clock_divider_q <= odcrc_pkg::CPU_CLOCK_DIVIDER_RST;
      mask_q <= 8'h00;
      flags_q <= odcrc_pkg::FLAGS_RST;
      div_upd_q <= 1'b0;
      irq_q <= 1'b0;
      wr_q <= '0;
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      b_v_q <= 1'b0;
      b_r_q <= odcrc_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      r_v_q <= 1'b0;
      r_d_q <= 32'h00000000;
      r_r_q <= odcrc_pkg::RESP_OKAY;
      pif_rdata_q <= 32'h00000000;
      pif_wr_q <= 1'b0;
   end
   else
   begin
      chan_q <= chan_d;
      gen_q <= gen_d;
      gate_q <= gate_d;
      gated_run_q <= gated_run_d;
      cpu_clock_divider_q <= cpu_clock_divider_d;
      mask_q <= mask_d;
      flags_q <= flags_d;
      div_upd_q <= div_upd_d;
      irq_q <= irq_d;
      wr_q <= wr_d;
      aw_v_q <= aw_v_d;
      w_v_q <= w_v_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      b_v_q <= b_v_d;
      b_r_q <= b_r_d;
      arready_q <= arready_d;
      r_v_q <= r_v_d;
      r_d_q <= r_d_d;
      r_r_q <= r_r_d;
      pif_rdata_q <= pif_rdata_d;
      pif_wr_q <= pif_wr_d;
   end
end

endmodule
